// File: ckg_clock_gen_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Fastest instruction takes two CPU clock periods.
// R2: CPU clock is system clock over 1..16.
// R3: Prescaler makes peripheral clock, then CPU clock.
// R4: Halt writes ignored when configuration forbids stopping.
// R5: Forbidden stopping forces watchdog to slow oscillator.
// R6: Slow mode register resets to zero, byte/bit writes.
// R7: Bit 0 one stops, zero runs slow oscillator.
// R8: Wake wait only after STOP, resonator source only.
// R9: Fast internal or external clock: no wake wait.
// R10: Wait codes give 2^10, 2^12, 2^15, 2^17 periods.
// R11: Software writes wake wait select as whole byte.
// R12: Wake wait select has no reset value.
// R13: Wait counts only after oscillation has started.
// R14: Software programs wait no shorter than resonator needs.
// R15: Configuration picks source and post-reset wait.
// R16: Fast internal source frees both oscillator pins.
// R17: Resonator source dedicates both oscillator pins.
// R18: External clock enters input pin; output pin free.
// R19: Peripheral codes: 1, 1/2, 1/4, 11 prohibited.
// R20: Both divider registers start at 02H.
// R21: CPU field plus peripheral field gives five ratios.
module ckg_clock_gen_ctrl
   import ckg_pkg::*;
#(
   parameter int WAIT_CYC0 = 2 ** CKG_WAIT_EXP0,
   parameter int WAIT_CYC1 = 2 ** CKG_WAIT_EXP1,
   parameter int WAIT_CYC2 = 2 ** CKG_WAIT_EXP2,
   parameter int WAIT_CYC3 = 2 ** CKG_WAIT_EXP3
) (
   // Clock and reset; aclk is the system clock.
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus write address and data.
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Register bus write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Register bus read.
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Non-volatile configuration.
   input wire logic [1:0] cfg_clock_source,
   input wire logic cfg_slow_stop_allowed,
   input wire logic [1:0] cfg_reset_wait_code,
   // Standby control from the CPU and oscillator.
   input wire logic stop_enter,
   input wire logic stop_release,
   input wire logic osc_started,
   // Clock enables and status.
   output logic periph_clk_tick,
   output logic cpu_clk_tick,
   output logic instr_slot_tick,
   output logic cpu_hold,
   output logic wake_wait_busy,
   // Slow oscillator and watchdog source.
   output logic slow_osc_run,
   output logic watchdog_src_forced,
   // Oscillator pin use.
   output logic osc_in_port_en,
   output logic osc_out_port_en,
   output logic osc_in_ext_clk
);

   // ==========================================================================
   // Registers and state.
   logic [7:0] slow_mode_q;
   logic [1:0] wake_code_q;
   logic [1:0] cpu_div_q;
   logic [1:0] periph_div_q;
   logic [15:0] aw_addr_q;
   logic aw_held_q;
   logic [7:0] w_data_q;
   logic w_lane_q;
   logic w_held_q;
   logic [4:0] pre_cnt_q;
   logic instr_ph_q;
   logic [CKG_WAIT_W-1:0] wait_cnt_q;
   logic [CKG_WAIT_W-1:0] wait_len;
   logic [1:0] active_code_q;
   ckg_state_t state_q;
   ckg_src_t src_q;
   logic do_write;
   logic [2:0] cpu_exp;
   logic [2:0] new_exp;
   logic [4:0] cpu_mask;
   logic [4:0] periph_mask;

   // A write completes once both address and data are held.
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

   // ==========================================================================
   // Write address and data capture, accepted in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 16'h0000;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !do_write;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
      end
   end

   // Write data capture; only the low byte lane and its strobe are kept.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane_q <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !do_write;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // Write response follows both halves; unmapped addresses get a decode error.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CKG_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         unique case (aw_addr_q)
            CKG_ADDR_SLOW_MODE, CKG_ADDR_WAKE_WAIT, CKG_ADDR_CPU_DIV,
            CKG_ADDR_PERIPH_DIV: s_axi_bresp <= CKG_RESP_OKAY;
            default: s_axi_bresp <= CKG_RESP_DECERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // Slow oscillator mode; stored only when the configuration permits stopping.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_mode_q <= CKG_SLOW_MODE_RST; // R6
      end else if (!cfg_slow_stop_allowed) begin
         slow_mode_q <= CKG_SLOW_MODE_RST; // R4
      end else if (do_write && w_lane_q && aw_addr_q == CKG_ADDR_SLOW_MODE) begin
         slow_mode_q <= {7'h00, w_data_q[CKG_HALT_BIT]}; // R6
      end
   end

   // Wake wait select has no reset; it is unknown until software writes it.
   always_ff @(posedge aclk) begin
      if (do_write && w_lane_q && aw_addr_q == CKG_ADDR_WAKE_WAIT) begin
         wake_code_q <= w_data_q[CKG_FIELD_HI:CKG_FIELD_LO]; // R12 R11
      end
   end

   // Divider writes that give a prohibited combination are ignored.
   always_comb begin
      new_exp = {1'b0, w_data_q[CKG_FIELD_HI:CKG_FIELD_LO]} + {1'b0, periph_div_q};
      if (aw_addr_q == CKG_ADDR_PERIPH_DIV) begin
         new_exp = {1'b0, w_data_q[CKG_FIELD_HI:CKG_FIELD_LO]} + {1'b0, cpu_div_q};
      end
   end

   // Divider registers; each keeps a two-bit field of its byte.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_div_q <= CKG_CPU_DIV_RST[CKG_FIELD_HI:CKG_FIELD_LO]; // R20
         periph_div_q <= CKG_PERIPH_DIV_RST[CKG_FIELD_HI:CKG_FIELD_LO]; // R20
      end else if (do_write && w_lane_q && new_exp <= CKG_MAX_CPU_EXP) begin
         if (aw_addr_q == CKG_ADDR_CPU_DIV) begin
            cpu_div_q <= w_data_q[CKG_FIELD_HI:CKG_FIELD_LO]; // R21
         end
         if (aw_addr_q == CKG_ADDR_PERIPH_DIV &&
             w_data_q[CKG_FIELD_HI:CKG_FIELD_LO] != CKG_PERIPH_BAD) begin
            periph_div_q <= w_data_q[CKG_FIELD_HI:CKG_FIELD_LO]; // R19
         end
      end
   end

   // ==========================================================================
   // Read channel.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= CKG_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= CKG_RESP_OKAY;
            unique case (s_axi_araddr)
               CKG_ADDR_SLOW_MODE: s_axi_rdata <= {24'h000000, slow_mode_q};
               CKG_ADDR_WAKE_WAIT: s_axi_rdata <= {30'h0000_0000, wake_code_q};
               CKG_ADDR_CPU_DIV: s_axi_rdata <= {30'h0000_0000, cpu_div_q};
               CKG_ADDR_PERIPH_DIV: s_axi_rdata <= {30'h0000_0000, periph_div_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= CKG_RESP_DECERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Prescaler: peripheral tick, then CPU tick from the combined ratio.
   assign cpu_exp = {1'b0, periph_div_q} + {1'b0, cpu_div_q};
   assign periph_mask = 5'((6'h01 << periph_div_q) - 6'h01); // R3
   assign cpu_mask = 5'((6'h01 << cpu_exp) - 6'h01); // R2

   // The free-running count gates the registered clock enables.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt_q <= 5'h00;
         periph_clk_tick <= 1'b0;
         cpu_clk_tick <= 1'b0;
         instr_slot_tick <= 1'b0;
         instr_ph_q <= 1'b0;
      end else begin
         pre_cnt_q <= pre_cnt_q + 5'h01;
         periph_clk_tick <= !cpu_hold && (pre_cnt_q & periph_mask) == 5'h00; // R3
         cpu_clk_tick <= !cpu_hold && (pre_cnt_q & cpu_mask) == 5'h00; // R2
         instr_slot_tick <= 1'b0;
         if (!cpu_hold && (pre_cnt_q & cpu_mask) == 5'h00) begin
            instr_ph_q <= instr_ph_q ^ 1'b1;
            instr_slot_tick <= instr_ph_q == CKG_INSTR_LAST; // R1
         end
      end
   end

   // ==========================================================================
   // Slow oscillator run, watchdog source and pin use.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_osc_run <= 1'b1;
         watchdog_src_forced <= 1'b1;
         osc_in_port_en <= 1'b0;
         osc_out_port_en <= 1'b0;
         osc_in_ext_clk <= 1'b0;
         src_q <= CKG_SRC_FAST_INT;
      end else begin
         slow_osc_run <= !(cfg_slow_stop_allowed && slow_mode_q[CKG_HALT_BIT]); // R7 R4
         watchdog_src_forced <= !cfg_slow_stop_allowed; // R5
         if (state_q == CKG_ST_INIT) begin
            src_q <= ckg_src_t'(cfg_clock_source); // R15
         end
         osc_in_port_en <= src_q == CKG_SRC_FAST_INT; // R16 R17
         osc_out_port_en <= src_q != CKG_SRC_RESONATOR; // R16 R17 R18
         osc_in_ext_clk <= src_q == CKG_SRC_EXT_CLK; // R18
      end
   end

   // ==========================================================================
   // Wake sequencer: the wait runs only for a resonator, after it oscillates.
   always_comb begin
      unique case (active_code_q)
         2'h0: wait_len = CKG_WAIT_W'(WAIT_CYC0); // R10
         2'h1: wait_len = CKG_WAIT_W'(WAIT_CYC1); // R10
         2'h2: wait_len = CKG_WAIT_W'(WAIT_CYC2); // R10
         2'h3: wait_len = CKG_WAIT_W'(WAIT_CYC3); // R10
      endcase
   end

   // Standby sequencer; the CPU stays held until its source is usable.
   // A resonator first waits for oscillation and then counts the wait.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= CKG_ST_INIT;
         wait_cnt_q <= '0;
         active_code_q <= 2'h0;
         cpu_hold <= 1'b1;
         wake_wait_busy <= 1'b0;
      end else begin
         unique case (state_q)
            CKG_ST_INIT: begin
               active_code_q <= cfg_reset_wait_code; // R15
               if (ckg_src_t'(cfg_clock_source) == CKG_SRC_RESONATOR) begin
                  state_q <= CKG_ST_WAIT_OSC;
               end else begin
                  state_q <= CKG_ST_RUN;
                  cpu_hold <= 1'b0;
               end
            end
            CKG_ST_RUN: if (stop_enter) begin
               state_q <= CKG_ST_STOPPED;
               cpu_hold <= 1'b1;
            end
            CKG_ST_STOPPED: if (stop_release) begin
               if (src_q == CKG_SRC_RESONATOR) begin
                  active_code_q <= wake_code_q; // R8
                  state_q <= CKG_ST_WAIT_OSC;
               end else begin
                  state_q <= CKG_ST_RUN; // R9
                  cpu_hold <= 1'b0;
               end
            end
            CKG_ST_WAIT_OSC: if (osc_started) begin
               state_q <= CKG_ST_COUNT; // R13
               wait_cnt_q <= '0;
               wake_wait_busy <= 1'b1;
            end
            CKG_ST_COUNT: begin
               wait_cnt_q <= wait_cnt_q + 1'b1;
               if (wait_cnt_q == wait_len - 1'b1) begin
                  state_q <= CKG_ST_RUN;
                  wake_wait_busy <= 1'b0;
                  cpu_hold <= 1'b0;
               end
            end
            default: begin
               state_q <= CKG_ST_INIT;
            end
         endcase
      end
   end

endmodule

// File: ckg_pkg.sv
// ==========================================================================
// Shared constants of the clock generator control block.
package ckg_pkg;

   // ==========================================================================
   // Register byte addresses on the register bus.
   localparam logic [15:0] CKG_ADDR_SLOW_MODE = 16'hFF58;
   localparam logic [15:0] CKG_ADDR_WAKE_WAIT = 16'hFFF4;
   localparam logic [15:0] CKG_ADDR_CPU_DIV = 16'hFFF8;
   localparam logic [15:0] CKG_ADDR_PERIPH_DIV = 16'hFFFC;

   // ==========================================================================
   // Values after reset.
   localparam logic [7:0] CKG_SLOW_MODE_RST = 8'h00;
   localparam logic [7:0] CKG_CPU_DIV_RST = 8'h02;
   localparam logic [7:0] CKG_PERIPH_DIV_RST = 8'h02;

   // ==========================================================================
   // Field positions.
   localparam int CKG_HALT_BIT = 0;
   localparam int CKG_FIELD_LO = 0;
   localparam int CKG_FIELD_HI = 1;

   // Largest total CPU division exponent (divide by sixteen).
   localparam logic [2:0] CKG_MAX_CPU_EXP = 3'h4;
   // Prohibited peripheral divider code.
   localparam logic [1:0] CKG_PERIPH_BAD = 2'h3;
   // Last CPU clock phase of the fastest instruction, which takes two periods.
   localparam logic [0:0] CKG_INSTR_LAST = 1'h1;

   // ==========================================================================
   // Wait lengths in system clock periods, as powers of two.
   localparam int CKG_WAIT_EXP0 = 10;
   localparam int CKG_WAIT_EXP1 = 12;
   localparam int CKG_WAIT_EXP2 = 15;
   localparam int CKG_WAIT_EXP3 = 17;
   localparam int CKG_WAIT_W = 18;

   // ==========================================================================
   // Bus response codes.
   localparam logic [1:0] CKG_RESP_OKAY = 2'h0;
   localparam logic [1:0] CKG_RESP_DECERR = 2'h3;

   // System clock source chosen by the non-volatile configuration.
   typedef enum logic [1:0] {
      CKG_SRC_FAST_INT,
      CKG_SRC_RESONATOR,
      CKG_SRC_EXT_CLK,
      CKG_SRC_RESERVED
   } ckg_src_t;

   // Wake sequencer states.
   typedef enum logic [2:0] {
      CKG_ST_INIT,
      CKG_ST_RUN,
      CKG_ST_STOPPED,
      CKG_ST_WAIT_OSC,
      CKG_ST_COUNT
   } ckg_state_t;

endpackage

// File: ckg_osc_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Resonator model: oscillation begins a set time after each restart.
module ckg_osc_model (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Restart request and start-up length in cycles.
   input wire logic restart,
   input wire logic [7:0] startup_cyc,
   // One-cycle pulse once oscillation has begun.
   output logic osc_started
);
   logic [7:0] cnt_q;
   logic run_q;

   // A reset or a restart loads the start-up delay, then one pulse is given.
   always_ff @(posedge aclk) begin
      osc_started <= 1'b0;
      if (!aresetn || restart) begin
         run_q <= 1'b1;
         cnt_q <= startup_cyc;
      end else if (run_q && cnt_q == 8'h00) begin
         run_q <= 1'b0;
         osc_started <= 1'b1;
      end else if (run_q) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule

// File: ckg_clock_gen_ctrl_asserts.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the clock generator control.
module ckg_clock_gen_ctrl_asserts #(
   parameter int WAIT_CYC0 = 4,
   parameter int WAIT_CYC1 = 8,
   parameter int WAIT_CYC2 = 16,
   parameter int WAIT_CYC3 = 32
) (
   // Clock, reset, configuration and oscillator start.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] cfg_clock_source,
   input wire logic cfg_slow_stop_allowed,
   input wire logic osc_started,
   // Watched outputs.
   input wire logic periph_clk_tick,
   input wire logic cpu_clk_tick,
   input wire logic cpu_hold,
   input wire logic wake_wait_busy,
   input wire logic slow_osc_run,
   input wire logic watchdog_src_forced,
   input wire logic osc_in_port_en,
   input wire logic osc_out_port_en,
   input wire logic osc_in_ext_clk
);
   int busy_n_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Counts the cycles of the running wake wait.
   always_ff @(posedge aclk) begin
      if (!aresetn || !wake_wait_busy) begin
         busy_n_q <= 0;
      end else begin
         busy_n_q <= busy_n_q + 1;
      end
   end

   property p_tick_nest;
      cpu_clk_tick |-> periph_clk_tick;
   endproperty
   a_tick_nest: assert property (p_tick_nest) else $error("cpu tick alone");
   property p_wd_forced;
      !cfg_slow_stop_allowed [*2] |-> watchdog_src_forced && slow_osc_run;
   endproperty
   a_wd_forced: assert property (p_wd_forced) else $error("slow clock not locked");
   property p_pins_int;
      cfg_clock_source == 2'h0 [*4] |-> osc_in_port_en && osc_out_port_en;
   endproperty
   a_pins_int: assert property (p_pins_int) else $error("pins not freed");
   property p_pins_res;
      cfg_clock_source == 2'h1 [*4] |-> !(osc_in_port_en || osc_out_port_en || osc_in_ext_clk);
   endproperty
   a_pins_res: assert property (p_pins_res) else $error("resonator pins freed");
   property p_pins_ext;
      cfg_clock_source == 2'h2 [*4] |-> osc_in_ext_clk && osc_out_port_en && !osc_in_port_en;
   endproperty
   a_pins_ext: assert property (p_pins_ext) else $error("external clock pins wrong");
   property p_no_wait;
      cfg_clock_source != 2'h1 |-> !wake_wait_busy;
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("wait without resonator");
   property p_wait_start;
      $rose(wake_wait_busy) |-> $past(osc_started);
   endproperty
   a_wait_start: assert property (p_wait_start) else $error("wait before start");
   property p_wait_len;
      $fell(wake_wait_busy) |-> !cpu_hold &&
         busy_n_q inside {WAIT_CYC0, WAIT_CYC1, WAIT_CYC2, WAIT_CYC3};
   endproperty
   a_wait_len: assert property (p_wait_len) else $error("wait length wrong");

   // Main scenarios reached.
   c_wait: cover property ($fell(wake_wait_busy));
   c_slow_off: cover property (!slow_osc_run);
   c_cpu_tick: cover property (cpu_clk_tick);
endmodule

bind ckg_clock_gen_ctrl ckg_clock_gen_ctrl_asserts #(.WAIT_CYC0(WAIT_CYC0),
   .WAIT_CYC1(WAIT_CYC1), .WAIT_CYC2(WAIT_CYC2), .WAIT_CYC3(WAIT_CYC3)) u_chk (.aclk, .aresetn,
   .cfg_clock_source, .cfg_slow_stop_allowed, .osc_started, .periph_clk_tick, .cpu_clk_tick,
   .cpu_hold, .wake_wait_busy, .slow_osc_run, .watchdog_src_forced, .osc_in_port_en,
   .osc_out_port_en, .osc_in_ext_clk);

// File: ckg_clock_gen_ctrl_tb_top.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the clock generator control.
module ckg_clock_gen_ctrl_tb_top;
   import ckg_pkg::*;
   localparam int WC [4] = '{4, 8, 16, 32};
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, cfg_slow_stop_allowed = 1;
   logic stop_enter = 0, stop_release = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, osc_started, periph_clk_tick, cpu_clk_tick;
   logic instr_slot_tick, cpu_hold, wake_wait_busy, slow_osc_run, watchdog_src_forced;
   logic osc_in_port_en, osc_out_port_en, osc_in_ext_clk;
   logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 0;
   logic [1:0] cfg_clock_source = 0, cfg_reset_wait_code = 1, s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] startup = 3;
   int mismatches = 0, tests_run = 0;

   ckg_clock_gen_ctrl #(.WAIT_CYC0(WC[0]), .WAIT_CYC1(WC[1]), .WAIT_CYC2(WC[2]),
      .WAIT_CYC3(WC[3])) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .cfg_clock_source, .cfg_slow_stop_allowed,
      .cfg_reset_wait_code, .stop_enter, .stop_release, .osc_started, .periph_clk_tick,
      .cpu_clk_tick, .instr_slot_tick, .cpu_hold, .wake_wait_busy, .slow_osc_run,
      .watchdog_src_forced, .osc_in_port_en, .osc_out_port_en, .osc_in_ext_clk);
   ckg_osc_model i_osc (.aclk, .aresetn, .restart(stop_release), .startup_cyc(startup),
      .osc_started);

   // 100 MHz clock.
   initial begin
      forever #5 aclk = ~aclk;
   end

   // Compares a value and counts the outcome.
   task automatic chk_v(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   // Compares a cycle or tick count.
   task automatic chk_c(input string n, input int e, input int g);
      chk_v(n, 32'(e), 32'(g));
   endtask

   // Bus write; the address and data are each released once taken.
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   // Bus read of one word into rd.
   task automatic rdr(input logic [15:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Waits for the CPU clock to resume and measures the wake wait.
   task automatic wake(input int len);
      int n = 0, early = 0;
      bit seen = 0;
      repeat (300) begin
         @(posedge aclk);
         seen = seen | osc_started;
         if (wake_wait_busy === 1'b1) n++;
         if (wake_wait_busy === 1'b1 && !seen) early++;
         if (cpu_hold === 1'b0) break;
      end
      chk_v("cpu_resumed", 32'h0, cpu_hold);
      chk_c("wait_cycles", len, n);
      chk_c("early_wait", 0, early);
   endtask

   // Reset under one clock source, then pin use and start-up wait.
   task automatic t_src(input logic [1:0] src, input logic [2:0] pins, input int len);
      aresetn <= 1'b0;
      cfg_clock_source <= src;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wake(len);
      repeat (2) @(posedge aclk);
      chk_v("pin_use", pins, {osc_in_port_en, osc_out_port_en, osc_in_ext_clk});
      $display("done source %0d", src);
   endtask

   // Reset values, unmapped place and byte strobe.
   task automatic t_regs;
      rdr(CKG_ADDR_CPU_DIV);
      chk_v("cpu_div_rst", 32'h2, rd);
      rdr(CKG_ADDR_PERIPH_DIV);
      chk_v("periph_div_rst", 32'h2, rd);
      rdr(CKG_ADDR_SLOW_MODE);
      chk_v("slow_mode_rst", 32'h0, rd);
      rdr(CKG_ADDR_WAKE_WAIT);
      chk_v("wake_sel_rst", {30'h0, 2'bxx}, rd);
      rdr(16'hFF00);
      chk_v("unmapped_rd", 32'h0, rd);
      chk_v("unmapped_rresp", CKG_RESP_DECERR, rsp);
      wr(16'hFF00, 8'h01, 4'h1);
      chk_v("unmapped_wr", CKG_RESP_DECERR, rsp);
      wr(CKG_ADDR_WAKE_WAIT, 8'h03, 4'h1);
      wr(CKG_ADDR_WAKE_WAIT, 8'h00, 4'h0);
      rdr(CKG_ADDR_WAKE_WAIT);
      chk_v("wake_sel", 32'h3, rd);
      $display("done registers");
   endtask

   // One divider pair for each of the five ratios, then the prohibited codes.
   task automatic t_div;
      int pp [5] = '{0, 1, 2, 2, 2};
      int pc [5] = '{0, 0, 0, 1, 2};
      int pn, cn, in;
      for (int i = 0; i < 5; i++) begin
         wr(CKG_ADDR_PERIPH_DIV, 8'(pp[i]), 4'h1);
         wr(CKG_ADDR_CPU_DIV, 8'(pc[i]), 4'h1);
         repeat (4) @(posedge aclk);
         pn = 0;
         cn = 0;
         in = 0;
         repeat (64) begin
            @(posedge aclk);
            pn += int'(periph_clk_tick);
            cn += int'(cpu_clk_tick);
            in += int'(instr_slot_tick);
         end
         chk_c("periph_ticks", 64 >> pp[i], pn);
         chk_c("cpu_ticks", 64 >> (pp[i] + pc[i]), cn);
         chk_c("instr_ticks", 32 >> (pp[i] + pc[i]), in);
      end
      wr(CKG_ADDR_PERIPH_DIV, 8'h03, 4'h1);
      rdr(CKG_ADDR_PERIPH_DIV);
      chk_v("periph_bad", 32'h2, rd);
      wr(CKG_ADDR_CPU_DIV, 8'h03, 4'h1);
      rdr(CKG_ADDR_CPU_DIV);
      chk_v("cpu_bad", 32'h2, rd);
      $display("done dividers");
   endtask

   // Slow oscillator halt with stopping allowed and forbidden.
   task automatic t_slow;
      wr(CKG_ADDR_SLOW_MODE, 8'h01, 4'h1);
      rdr(CKG_ADDR_SLOW_MODE);
      chk_v("slow_halt", 9'h002, {rd[7:0], slow_osc_run});
      wr(CKG_ADDR_SLOW_MODE, 8'h00, 4'h1);
      chk_v("slow_run", 1, slow_osc_run);
      cfg_slow_stop_allowed <= 1'b0;
      wr(CKG_ADDR_SLOW_MODE, 8'h01, 4'h1);
      rdr(CKG_ADDR_SLOW_MODE);
      chk_v("slow_locked", 10'h003, {rd[7:0], slow_osc_run, watchdog_src_forced});
      cfg_slow_stop_allowed <= 1'b1;
      repeat (3) @(posedge aclk);
      chk_v("wd_free", 0, watchdog_src_forced);
      $display("done slow oscillator");
   endtask

   // Enters STOP, releases it and checks the wait applied.
   task automatic t_stop(input logic [1:0] code, input int len);
      wr(CKG_ADDR_WAKE_WAIT, {6'h0, code}, 4'h1);
      stop_enter <= 1'b1;
      @(posedge aclk);
      stop_enter <= 1'b0;
      repeat (2) @(posedge aclk);
      chk_v("hold_in_stop", 1, cpu_hold);
      stop_release <= 1'b1;
      @(posedge aclk);
      stop_release <= 1'b0;
      wake(len);
      $display("done stop code %0d", code);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence over the three clock sources.
   initial begin
      t_src(2'h0, 3'b110, 0);
      t_regs();
      t_div();
      t_slow();
      t_stop(2'h3, 0);
      t_src(2'h2, 3'b011, 0);
      t_stop(2'h2, 0);
      t_src(2'h1, 3'b000, WC[1]);
      for (int c = 0; c < 4; c++) begin
         startup <= (c % 2 == 1) ? 8'h09 : 8'h02;
         t_stop(2'(c), WC[c]);
      end
      results();
   end

   // The tests need well under 1000 cycles; this limit of 50000 cycles is over fifty times that.
   initial begin
      #500us;
      mismatches++;
      results();
   end
endmodule
